// ==== gated_timer_pkg.sv ====
// Purpose: constants and types for the gated sixteen bit timer
// Assumes: APB register bus, word per register, byte address = 4 * index
// Notes: indices below are the register numbers, not byte addresses
// Functional notes
// - 16-bit count wraps to zero, sets flag
// - Timer mode counts instruction cycles after prescale
// - Counter mode counts external rising edges
// - Falling edge must precede first counted rise
// - Interrupt needs flag, overflow, peripheral, global enables
// - Flag stays set until software clears
// - Prescale codes give 1, 2, 4, 8
// - Count byte write clears hidden prescaler
// - Run bit starts and stops, resets zero
// - Gate enable counts only while gate low
// - Source bit picks external pin or Fosc/4
// - Sync bit chooses synchronised or unsynchronised input; here pins are always synchronised, bit only enables sleep counting
// - Crystal enable works only with internal oscillator
// - Asynchronous counter keeps counting during sleep
// - Each byte read returns a valid value
// - Crystal enable forces pin 4 and 5 directions to one
// - Sleep counting only asynchronous; wake needs enables
// - Wake with global enable enters service routine
package gated_timer_pkg;

  localparam int ADDR_W = 12;
  localparam logic [9:0] IDX_INTERRUPT_CONTROL = 10'h00b;
  localparam logic [9:0] IDX_PERIPHERAL_IRQ_FLAGS = 10'h00c;
  localparam logic [9:0] IDX_COUNT_LOW_BYTE = 10'h00e;
  localparam logic [9:0] IDX_COUNT_HIGH_BYTE = 10'h00f;
  localparam logic [9:0] IDX_TIMER_CONTROL = 10'h010;
  localparam logic [9:0] IDX_PERIPHERAL_IRQ_ENABLES = 10'h08c;
  localparam logic [9:0] IDX_PIN_DIRECTION = 10'h085;
  localparam logic [9:0] IDX_PIN_LEVELS = 10'h005;

  localparam int GLOBAL_IRQ_ENABLE_BIT = 7;
  localparam int PERIPHERAL_IRQ_ENABLE_BIT = 6;
  localparam int OVERFLOW_FLAG_BIT = 0;
  localparam int OVERFLOW_IRQ_ENABLE_BIT = 0;
  localparam int PIN4_DIRECTION_BIT = 4;
  localparam int PIN5_DIRECTION_BIT = 5;

  localparam logic [7:0] INTERRUPT_CONTROL_RESET = 8'h00;
  localparam logic [7:0] TIMER_CONTROL_RESET = 8'h00;
  localparam logic [5:0] PIN_DIRECTION_RESET = 6'h3f;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hffff;

  // Fosc is pclk; the instruction cycle is four of them
  localparam int INSTR_CLOCK_DIV = 4;
  localparam logic [1:0] INSTR_DIV_LAST = 2'(INSTR_CLOCK_DIV - 1);

  // Pin vector layout through the input synchroniser
  localparam int PIN_EXT_COUNT = 6;
  localparam int PIN_GATE_N = 7;
  localparam int PIN_CRYSTAL = 8;
  localparam int PIN_VEC_W = 9;

  typedef struct packed {
    logic reserved;
    logic gate_enable;
    logic [1:0] input_prescale_select;
    logic crystal_osc_enable;
    logic ext_sync_disable;
    logic clock_source_select;
    logic counter_run;
  } timer_control_type;

endpackage

// ==== gated_sixteen_bit_timer.sv ====
// Purpose: sixteen bit timer/counter with gate, prescaler and overflow flag
// Assumes: one clock pclk; all pins are sampled through three flops
// Notes: asynchronous mode is modelled on pclk; it differs only in sleep behaviour
//
// Implementation choice: the APB register port.
module gated_sixteen_bit_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [gated_timer_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_count_input,
  input wire logic gate_input_n,
  input wire logic crystal_clock_in,
  input wire logic [5:0] port_pins_in,
  input wire logic internal_oscillator,
  input wire logic sleep_mode,
  output logic [5:0] pin_direction_out,
  output logic irq_request,
  output logic wake_request,
  output logic wake_to_isr,
  output logic wake_resume
);
  import gated_timer_pkg::*;

  function automatic logic index_hit(input logic [ADDR_W-1:0] addr, input logic [9:0] idx);
    index_hit = (addr[ADDR_W-1:2] == idx) && (addr[1:0] == 2'b00);
  endfunction

  // Register state
  logic [7:0] intctl_r;
  logic flag_r;
  logic ovf_ie_r;
  timer_control_type tctl_r;
  logic [5:0] dir_r;
  logic [15:0] count_r;
  logic [2:0] presc_r;
  logic [1:0] div_r;
  logic armed_r;
  logic ext_prev_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic irq_r;
  logic wake_r;
  logic wake_isr_r;
  logic wake_resume_r;

  // Input synchroniser
  logic [PIN_VEC_W-1:0] sync1_r;
  logic [PIN_VEC_W-1:0] sync2_r;
  logic [PIN_VEC_W-1:0] sync3_r;
  logic [PIN_VEC_W-1:0] filt_r;
  wire [PIN_VEC_W-1:0] pins_raw = {crystal_clock_in, gate_input_n, external_count_input, port_pins_in};
  // A level change counts only once stages two and three agree
  wire [PIN_VEC_W-1:0] filt_nxt = (sync2_r & sync3_r) | (filt_r & (sync2_r | sync3_r));

  // Bus decode
  wire setup_phase = psel && !penable;
  wire wr_en = psel && penable && pwrite;
  wire hit_intctl = index_hit(paddr, IDX_INTERRUPT_CONTROL);
  wire hit_flags = index_hit(paddr, IDX_PERIPHERAL_IRQ_FLAGS);
  wire hit_low = index_hit(paddr, IDX_COUNT_LOW_BYTE);
  wire hit_high = index_hit(paddr, IDX_COUNT_HIGH_BYTE);
  wire hit_tctl = index_hit(paddr, IDX_TIMER_CONTROL);
  wire hit_enables = index_hit(paddr, IDX_PERIPHERAL_IRQ_ENABLES);
  wire hit_dir = index_hit(paddr, IDX_PIN_DIRECTION);
  wire hit_levels = index_hit(paddr, IDX_PIN_LEVELS);
  wire hit_any = hit_intctl | hit_flags | hit_low | hit_high | hit_tctl | hit_enables | hit_dir | hit_levels;
  wire wr_low = wr_en && hit_low;
  wire wr_high = wr_en && hit_high;
  wire cnt_wr = wr_low || wr_high;
  wire wr_flags = wr_en && hit_flags;

  wire global_irq_enable = intctl_r[GLOBAL_IRQ_ENABLE_BIT];
  wire peripheral_irq_enable = intctl_r[PERIPHERAL_IRQ_ENABLE_BIT];

  // crystal only usable under internal oscillator
  wire osc_eff = tctl_r.crystal_osc_enable && internal_oscillator;

  // external level is the crystal when it is enabled, else the pin
  wire ext_level = osc_eff ? filt_r[PIN_CRYSTAL] : filt_r[PIN_EXT_COUNT];
  wire ext_rise = ext_level && !ext_prev_r;
  wire ext_fall = !ext_level && ext_prev_r;
  wire ext_src = tctl_r.clock_source_select;
  // sync bit only matters with the external source
  wire async_mode = ext_src && tctl_r.ext_sync_disable;

  // Instruction clock stops in sleep
  wire instr_tick = (div_r == INSTR_DIV_LAST) && !sleep_mode;

  // falling edge arms the counter input
  wire ext_evt = ext_rise && armed_r;
  wire armed_nxt = (!tctl_r.counter_run || !ext_src) ? 1'b0 : (ext_fall ? 1'b1 : armed_r);

  // internal source ticks once per instruction cycle
  wire src_evt = ext_src ? ext_evt : instr_tick;

  // gate pin low enables counting when gate is used
  wire gate_open = !tctl_r.gate_enable || !filt_r[PIN_GATE_N];
  // asynchronous counter alone runs during sleep
  // sleep counting restricted to asynchronous mode
  wire sleep_ok = !sleep_mode || async_mode;
  // run bit starts and stops counting
  wire count_on = tctl_r.counter_run && gate_open && sleep_ok;
  wire presc_adv = src_evt && count_on;

  // prescale division by 1, 2, 4 or 8
  wire [2:0] presc_mask = 3'((4'h1 << tctl_r.input_prescale_select) - 4'h1);
  wire inc = presc_adv && (presc_r == presc_mask);
  wire [2:0] presc_nxt = cnt_wr ? 3'h0 : (presc_adv ? (inc ? 3'h0 : presc_r + 3'h1) : presc_r);

  // wrap past maximum sets the flag
  // a write racing an increment wins; software should stop first
  wire overflow = inc && (count_r == COUNT_MAX) && !cnt_wr;
  wire [15:0] count_nxt = wr_low ? {count_r[15:8], pwdata[7:0]} :
                          wr_high ? {pwdata[7:0], count_r[7:0]} :
                          inc ? count_r + 16'h0001 : count_r;

  // flag held until software writes zero
  wire flag_nxt = overflow ? 1'b1 : (wr_flags ? pwdata[OVERFLOW_FLAG_BIT] : flag_r);

  // interrupt only with all three enables
  wire irq_nxt = flag_r && ovf_ie_r && peripheral_irq_enable && global_irq_enable;
  // wake needs run, overflow and peripheral enables
  wire wake_nxt = sleep_mode && tctl_r.counter_run && flag_r && ovf_ie_r && peripheral_irq_enable;

  // crystal forces both pin directions high
  wire [5:0] dir_eff = dir_r | (osc_eff ? 6'h30 : 6'h00);
  wire [5:0] levels_eff = filt_r[5:0] & (osc_eff ? 6'h0f : 6'h3f);

  // byte reads come from the registered count, always a settled value
  wire [7:0] rd_byte = hit_intctl ? intctl_r :
                       hit_flags ? {7'h00, flag_r} :
                       hit_low ? count_r[7:0] :
                       hit_high ? count_r[15:8] :
                       hit_tctl ? {1'b0, tctl_r[6:0]} :
                       hit_enables ? {7'h00, ovf_ie_r} :
                       hit_dir ? {2'b00, dir_eff} :
                       hit_levels ? {2'b00, levels_eff} : 8'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
      filt_r <= '0;
    end else begin
      sync1_r <= pins_raw;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      filt_r <= filt_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= 2'h0;
      ext_prev_r <= 1'b0;
      armed_r <= 1'b0;
      presc_r <= 3'h0;
      count_r <= COUNT_RESET;
      flag_r <= 1'b0;
    end else begin
      div_r <= div_r + 2'h1;
      ext_prev_r <= ext_level;
      armed_r <= armed_nxt;
      // count byte writes clear the prescaler
      presc_r <= presc_nxt;
      count_r <= count_nxt;
      flag_r <= flag_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      intctl_r <= INTERRUPT_CONTROL_RESET;
      ovf_ie_r <= 1'b0;
      tctl_r <= TIMER_CONTROL_RESET;
      dir_r <= PIN_DIRECTION_RESET;
    end else if (wr_en) begin
      if (hit_intctl) begin
        intctl_r <= pwdata[7:0];
      end
      if (hit_enables) begin
        ovf_ie_r <= pwdata[OVERFLOW_IRQ_ENABLE_BIT];
      end
      if (hit_tctl) begin
        tctl_r <= {1'b0, pwdata[6:0]};
      end
      if (hit_dir) begin
        dir_r <= pwdata[5:0];
      end
    end
  end

  // Read data captured in setup so it comes from a flop in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (setup_phase) begin
      prdata_r <= {24'h000000, rd_byte};
      pslverr_r <= !hit_any;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
      wake_r <= 1'b0;
      wake_isr_r <= 1'b0;
      wake_resume_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
      wake_r <= wake_nxt;
      // global enable set means vector to the service routine
      wake_isr_r <= wake_nxt && global_irq_enable;
      // global enable clear means continue after sleep
      wake_resume_r <= wake_nxt && !global_irq_enable;
    end
  end

  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = pslverr_r;
  assign pin_direction_out = dir_eff;
  assign irq_request = irq_r;
  assign wake_request = wake_r;
  assign wake_to_isr = wake_isr_r;
  assign wake_resume = wake_resume_r;

  a_wrap_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
    overflow |=> flag_r && (count_r == COUNT_RESET))
    else $error("wrap did not clear count and set flag");

  a_flag_stays_set: assert property (@(posedge pclk) disable iff (!presetn)
    (flag_r && !wr_flags) |=> flag_r)
    else $error("overflow flag cleared without software");

  a_irq_needs_enables: assert property (@(posedge pclk) disable iff (!presetn)
    irq_request |-> $past(global_irq_enable) && $past(peripheral_irq_enable) && $past(ovf_ie_r) && $past(flag_r))
    else $error("interrupt raised without all enables");

  a_stopped_count_holds: assert property (@(posedge pclk) disable iff (!presetn)
    (!tctl_r.counter_run && !cnt_wr) |=> $stable(count_r))
    else $error("count moved while stopped");

  a_write_clears_prescale: assert property (@(posedge pclk) disable iff (!presetn)
    cnt_wr |=> (presc_r == 3'h0))
    else $error("prescaler not cleared by count write");

  a_rise_needs_arm: assert property (@(posedge pclk) disable iff (!presetn)
    (ext_src && tctl_r.counter_run && ext_rise && !armed_r && !cnt_wr) |=> $stable(count_r))
    else $error("rising edge counted before falling edge");

  a_gate_blocks_count: assert property (@(posedge pclk) disable iff (!presetn)
    (tctl_r.gate_enable && filt_r[PIN_GATE_N] && !cnt_wr) |=> $stable(count_r))
    else $error("count moved while gate high");

  a_sleep_sync_halts: assert property (@(posedge pclk) disable iff (!presetn)
    (sleep_mode && !async_mode && !cnt_wr) |=> $stable(count_r))
    else $error("count moved in sleep outside asynchronous mode");

  a_crystal_forces_dir: assert property (@(posedge pclk) disable iff (!presetn)
    osc_eff |-> (pin_direction_out[PIN5_DIRECTION_BIT] && pin_direction_out[PIN4_DIRECTION_BIT]))
    else $error("pin directions not forced by crystal");

  a_prescale_eight_spacing: assert property (@(posedge pclk) disable iff (!presetn)
    (inc && (tctl_r.input_prescale_select == 2'b11) && !ext_src && $stable(tctl_r))
      |=> !inc [*8])
    else $error("divide by eight incremented too soon");

  a_wake_isr_select: assert property (@(posedge pclk) disable iff (!presetn)
    wake_to_isr |-> wake_request && $past(global_irq_enable))
    else $error("service routine wake without global enable");

  // Wake flavours are exclusive; the core must never see both
  a_wake_resume_select: assert property (@(posedge pclk) disable iff (!presetn)
    wake_resume |-> wake_request && !$past(global_irq_enable))
    else $error("resume wake with global enable set");

  a_wake_exclusive: assert property (@(posedge pclk) disable iff (!presetn)
    !(wake_to_isr && wake_resume))
    else $error("both wake flavours raised");

  a_wake_needs_enables: assert property (@(posedge pclk) disable iff (!presetn)
    wake_request |-> $past(sleep_mode) && $past(tctl_r.counter_run) && $past(flag_r)
      && $past(ovf_ie_r) && $past(peripheral_irq_enable))
    else $error("wake raised without run and enables");

  a_irq_follows_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (flag_r && ovf_ie_r && peripheral_irq_enable && global_irq_enable) |=> irq_request)
    else $error("interrupt missing with all enables");

  // Polling software relies on the flag with every enable clear
  a_flag_sets_unmasked: assert property (@(posedge pclk) disable iff (!presetn)
    (overflow && !ovf_ie_r) |=> flag_r)
    else $error("flag not set with interrupt masked");

  a_flag_clear_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_flags && !overflow && !pwdata[OVERFLOW_FLAG_BIT]) |=> !flag_r)
    else $error("software clear of flag lost");

  a_count_steps_one: assert property (@(posedge pclk) disable iff (!presetn)
    (inc && !cnt_wr) |=> (count_r == $past(count_r) + 16'h0001))
    else $error("count did not step by one");

  // Byte writes touch only their own half of the count
  a_low_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
    wr_low |=> (count_r[7:0] == $past(pwdata[7:0])) && (count_r[15:8] == $past(count_r[15:8])))
    else $error("low byte write did not land");

  a_high_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
    wr_high |=> (count_r[15:8] == $past(pwdata[7:0])) && (count_r[7:0] == $past(count_r[7:0])))
    else $error("high byte write did not land");

  a_tick_spacing: assert property (@(posedge pclk) disable iff (!presetn)
    (inc && !ext_src && (tctl_r.input_prescale_select == 2'b00) && $stable(tctl_r))
      |=> !inc [*3])
    else $error("internal count faster than instruction cycle");

  a_prescale_two_spacing: assert property (@(posedge pclk) disable iff (!presetn)
    (inc && (tctl_r.input_prescale_select == 2'b01) && !ext_src && $stable(tctl_r))
      |=> !inc [*7])
    else $error("divide by two incremented too soon");

  // Stale arming would let the first rise after a restart count
  a_stopped_disarms: assert property (@(posedge pclk) disable iff (!presetn)
    !tctl_r.counter_run |=> !armed_r)
    else $error("input armed while stopped");

  a_internal_sleeps: assert property (@(posedge pclk) disable iff (!presetn)
    (sleep_mode && !ext_src && !cnt_wr) |=> $stable(count_r))
    else $error("internal count moved in sleep");

  a_read_low_byte: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_phase && hit_low) |=> (prdata[7:0] == $past(count_r[7:0])))
    else $error("low byte read not the count");

  a_read_high_byte: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_phase && hit_high) |=> (prdata[7:0] == $past(count_r[15:8])))
    else $error("high byte read not the count");

  a_read_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
    prdata[31:8] == 24'h000000)
    else $error("upper read data not zero");

  a_unmapped_error: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_phase && !hit_any) |=> pslverr)
    else $error("unmapped access without error");

  // Under the crystal the shared pins must read low
  a_crystal_levels_low: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_phase && hit_levels && osc_eff) |=> (prdata[5:4] == 2'b00))
    else $error("crystal pins did not read zero");

endmodule

// ==== ext_count_source.sv ====
// Purpose: far-side model of the count pin, gate pin and crystal
// Assumes: each level is held ten clocks, beyond sync and filter
// Notes: crystal idles low; xtal_pulses drives crystal traffic shaped like the pin
module ext_count_source (
  output logic external_count_input,
  output logic gate_input_n,
  output logic crystal_clock_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    external_count_input = 1'b1;
    gate_input_n = 1'b1;
    crystal_clock_in = 1'b0;
  end
  task automatic pulses(input int n);
    repeat (n) begin
      #80 external_count_input = 1'b0;
      #80 external_count_input = 1'b1;
    end
    // Let the last rise pass sync and filter before anyone stops the counter
    #80;
  endtask
  // crystal level pulses, same shape as the pin
  task automatic xtal_pulses(input int n);
    repeat (n) begin
      #80 crystal_clock_in = 1'b0;
      #80 crystal_clock_in = 1'b1;
    end
    #80;
  endtask
  task automatic level(input logic v);
    external_count_input = v;
  endtask
  task automatic gate(input logic v);
    gate_input_n = v;
  endtask
endmodule

// ==== tb_top.sv ====
// Purpose: self-checking bench for the gated sixteen bit timer
// Assumes: zero wait state APB slave, pclk 125 MHz
// Notes: the low count byte preset before the wrap is random from a fixed seed
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import gated_timer_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, ext_in, gate_n, xtal;
  logic internal_oscillator, sleep_mode, irq_request, wake_request, wake_to_isr, wake_resume;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [5:0] port_pins_in, pin_direction_out;
  logic [7:0] rd, lo;
  logic [15:0] cnt;
  int failures, n_compared, v;
  ext_count_source u_ext_count_source (.external_count_input(ext_in), .gate_input_n(gate_n),
    .crystal_clock_in(xtal));
  gated_sixteen_bit_timer u_gated_sixteen_bit_timer (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .external_count_input(ext_in), .gate_input_n(gate_n),
    .crystal_clock_in(xtal), .port_pins_in(port_pins_in), .internal_oscillator(internal_oscillator),
    .sleep_mode(sleep_mode), .pin_direction_out(pin_direction_out), .irq_request(irq_request),
    .wake_request(wake_request), .wake_to_isr(wake_to_isr), .wake_resume(wake_resume));
  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_rng(input string what, input int l, input int h, input logic [15:0] got);
    n_compared++;
    if ($isunknown(got) || got < l || got > h) begin
      failures++;
      $display("ERROR %s expected %0d..%0d seen %h", what, l, h, got);
    end
  endtask
  task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // counter is stopped before count writes
  task automatic start_cnt(input logic [7:0] ctrl);
    apb(1'b1, IDX_COUNT_LOW_BYTE, 8'h00);
    apb(1'b1, IDX_COUNT_HIGH_BYTE, 8'h00);
    apb(1'b1, IDX_TIMER_CONTROL, ctrl);
  endtask
  task automatic stop_cnt;
    apb(1'b1, IDX_TIMER_CONTROL, 8'h00);
    apb(1'b0, IDX_COUNT_LOW_BYTE, 8'h00);
    lo = rd;
    apb(1'b0, IDX_COUNT_HIGH_BYTE, 8'h00);
    cnt = {rd, lo};
  endtask
  task automatic close_out;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    repeat (40000) @(posedge pclk);
    failures++;
    close_out();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, internal_oscillator, sleep_mode} = '0;
    port_pins_in = 6'h3f;
    failures = 0;
    n_compared = 0;
    v = $urandom(6906);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, IDX_TIMER_CONTROL, 8'h00);
    check8("control reset", 8'h00, rd);
    apb(1'b1, IDX_TIMER_CONTROL + 10'h001, 8'h00);
    check8("unmapped error", 8'h01, {7'h0, err});
    check8("ready level", 8'h01, {7'h0, pready});
    $display("test reset done");
    for (int ps = 0; ps < 4; ps++) begin
      start_cnt({2'b00, 2'(ps), 4'b0001});
      repeat (80 << ps) @(posedge pclk);
      stop_cnt();
      check_rng("prescaled count", 19, 21, cnt);
    end
    start_cnt(8'h31);
    repeat (24) @(posedge pclk);
    apb(1'b1, IDX_COUNT_LOW_BYTE, 8'h00);
    repeat (20) @(posedge pclk);
    stop_cnt();
    check8("count after prescaler clear", 8'h00, lo);
    $display("test prescale done");
    for (int g = 0; g < 2; g++) begin
      u_ext_count_source.gate(g[0]);
      start_cnt(8'h41);
      repeat (80) @(posedge pclk);
      stop_cnt();
      check_rng("gated count", g ? 0 : 18, g ? 0 : 21, cnt);
    end
    $display("test gate done");
    for (int m = 0; m < 2; m++) begin
      u_ext_count_source.level(1'b0);
      start_cnt(m ? 8'h07 : 8'h03);
      u_ext_count_source.pulses(5);
      stop_cnt();
      check_rng("external count", 4, 4, cnt);
      start_cnt(m ? 8'h07 : 8'h03);
      sleep_mode <= 1'b1;
      u_ext_count_source.pulses(5);
      @(posedge pclk);
      sleep_mode <= 1'b0;
      stop_cnt();
      check_rng("sleep count", m ? 5 : 0, m ? 5 : 0, cnt);
    end
    $display("test external done");
    v = $urandom % 256;
    apb(1'b1, IDX_COUNT_LOW_BYTE, 8'(v));
    apb(1'b1, IDX_COUNT_HIGH_BYTE, 8'hff);
    apb(1'b1, IDX_TIMER_CONTROL, 8'h01);
    repeat ((256 - v) * 4 + 8) @(posedge pclk);
    stop_cnt();
    check8("high byte after wrap", 8'h00, cnt[15:8]);
    apb(1'b0, IDX_PERIPHERAL_IRQ_FLAGS, 8'h00);
    check8("overflow flag", 8'h01, rd);
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, IDX_PERIPHERAL_IRQ_ENABLES, {7'h00, c[0]});
      apb(1'b1, IDX_INTERRUPT_CONTROL, {c[2], c[1], 6'h00});
      repeat (2) @(posedge pclk);
      check8("irq request", {7'h00, c == 7}, {7'h00, irq_request});
    end
    apb(1'b1, IDX_TIMER_CONTROL, 8'h01);
    sleep_mode <= 1'b1;
    for (int gi = 0; gi < 2; gi++) begin
      apb(1'b1, IDX_INTERRUPT_CONTROL, {gi[0], 7'h40});
      repeat (2) @(posedge pclk);
      check8("wake outputs", {5'h0, 1'b1, gi[0], !gi[0]}, {5'h0, wake_request, wake_to_isr, wake_resume});
    end
    apb(1'b0, IDX_COUNT_LOW_BYTE, 8'h00);
    lo = rd;
    repeat (40) @(posedge pclk);
    apb(1'b0, IDX_COUNT_LOW_BYTE, 8'h00);
    check8("count held in sleep", lo, rd);
    sleep_mode <= 1'b0;
    apb(1'b1, IDX_TIMER_CONTROL, 8'h00);
    apb(1'b0, IDX_PERIPHERAL_IRQ_FLAGS, 8'h00);
    check8("flag still set", 8'h01, rd);
    apb(1'b1, IDX_PERIPHERAL_IRQ_FLAGS, 8'h00);
    repeat (2) @(posedge pclk);
    check8("irq after clear", 8'h00, {7'h0, irq_request});
    $display("test overflow done");
    apb(1'b1, IDX_PIN_DIRECTION, 8'h00);
    apb(1'b1, IDX_TIMER_CONTROL, 8'h08);
    check8("direction no osc", 8'h00, {2'b00, pin_direction_out});
    internal_oscillator <= 1'b1;
    apb(1'b0, IDX_PIN_DIRECTION, 8'h00);
    check8("direction read", 8'h30, rd);
    check8("direction out", 8'h30, {2'b00, pin_direction_out});
    apb(1'b0, IDX_PIN_LEVELS, 8'h00);
    check8("pin levels", 8'h0f, rd);
    repeat (50) @(posedge pclk);
    start_cnt(8'h0b);
    u_ext_count_source.xtal_pulses(5);
    stop_cnt();
    check_rng("crystal count", 4, 4, cnt);
    $display("test crystal done");
    close_out();
  end
endmodule
